// >>> design/sleep_wake_ctrl.sv
// Power-down entry, wake-up sequencing, watchdog and interrupt flag registers.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
module sleep_wake_ctrl
	import sleep_wake_pkg::*;
#(
	parameter int WDT_TICKS   = 2048,
	parameter int OST_LENGTH  = OST_PERIODS
) (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Core
	input  wire logic        sleep_instr_i,
	input  wire logic        clear_wdt_i,
	output logic             cpu_clk_en_o,
	output logic             prefetch_o,
	output logic             sleep_nop_o,
	output logic             resume_o,
	output logic             vector_o,
	output logic      [15:0] vector_addr_o,
	// Reset sources and reset output
	input  wire logic        external_reset_pin_i,
	input  wire logic        brownout_reset_i,
	input  wire logic        por_reset_i,
	output logic             device_reset_o,
	// Clocking and configuration
	input  wire logic [1:0]  wdt_mode_i,
	input  wire logic        crystal_mode_i,
	input  wire logic        slow_osc_tick_i,
	input  wire logic        osc_tick_i,
	output logic             slow_osc_en_o,
	output logic             timer_osc_en_o,
	output logic             converter_clk_en_o,
	output logic             cap_osc_en_o,
	output logic             port_hold_o,
	// Interrupt events
	input  wire logic        tmr0_evt_i,
	input  wire logic        ext_int_evt_i,
	input  wire logic [5:0]  pin_rise_i,
	input  wire logic [5:0]  pin_fall_i,
	input  wire logic [7:0]  periph_one_evt_i,
	input  wire logic [4:0]  periph_two_evt_i,
	// Watchdog status
	output logic             wdt_running_o
);
	initial begin
		if (WDT_TICKS < 2 || WDT_TICKS > 16777215) $error("WDT_TICKS out of range");
		if (OST_LENGTH < 1 || OST_LENGTH > 65535) $error("OST_LENGTH out of range");
	end
	localparam logic [23:0] WDT_LAST = 24'(WDT_TICKS - 1);

	pwr_state_t  state_ff;
	pwr_state_t  nxt_state;
	logic [7:0]  irq_en_ff;
	logic [7:0]  pie_one_ff;
	logic [7:0]  pie_two_ff;
	logic [7:0]  status_ff;
	logic [7:0]  wdt_ctrl_ff;
	logic [7:0]  fall_en_ff;
	logic [7:0]  rise_en_ff;
	logic [23:0] wdt_cnt_ff;
	logic        gie_at_wake_ff;
	logic        resume_ff;
	logic        vector_ff;
	logic        prefetch_ff;
	logic        nop_ff;
	logic        reset_ff;
	logic [31:0] prdata_ff;

	// Bus decode.
	logic        wr_stb;
	logic        addr_hit;
	logic [7:0]  wdat;
	logic [7:0]  rdat;
	assign wdat   = pwdata_i[7:0];
	assign wr_stb = psel_i && penable_i && pwrite_i && addr_hit;

	// Reset requests and watchdog.
	logic full_reset_req;
	logic wdt_enabled;
	logic wdt_timeout;
	logic asleep;
	logic wdt_clr;
	logic enter_sleep;
	logic wake_evt;
	logic ost_start;
	logic ost_done;
	assign asleep = (state_ff != ST_AWAKE);
	assign full_reset_req = external_reset_pin_i || brownout_reset_i || por_reset_i; // see R09

	// Flag banks.
	logic [2:0] core_flags;
	logic [2:0] core_set;
	logic [7:0] pin_flags;
	logic [7:0] pir_one;
	logic [7:0] pir_two;
	logic [5:0] pin_set;
	assign pin_set  = (pin_rise_i & rise_en_ff[5:0]) | (pin_fall_i & fall_en_ff[5:0]);
	assign core_set = {tmr0_evt_i, ext_int_evt_i, 1'b0};

	sticky_flags #(
		.W(3)
	) u_core_flags (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.sync_clr_i(reset_ff),
		.wr_en_i   (wr_stb && paddr_i == OFS_IRQ_GLOBAL),
		.wr_data_i ({wdat[TMR0_FLAG_BIT], wdat[EXT_FLAG_BIT], 1'b0}),
		.set_i     (core_set),
		.flags_o   (core_flags)
	);

	sticky_flags #(
		.W(8)
	) u_pin_flags (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.sync_clr_i(reset_ff),
		.wr_en_i   (wr_stb && paddr_i == OFS_PIN_FLAGS),
		.wr_data_i (wdat & PIN_MSK),
		.set_i     ({2'b00, pin_set}),
		.flags_o   (pin_flags)
	);

	sticky_flags #(
		.W(8)
	) u_pir_one (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.sync_clr_i(reset_ff),
		.wr_en_i   (wr_stb && paddr_i == OFS_PIR_ONE),
		.wr_data_i (wdat),
		.set_i     (periph_one_evt_i),
		.flags_o   (pir_one)
	);

	// Bit 7 oscillator fail, 6 comparator b, 5 comparator a, 4 nvm write done, 3 collision.
	sticky_flags #(
		.W(8)
	) u_pir_two (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.sync_clr_i(reset_ff),
		.wr_en_i   (wr_stb && paddr_i == OFS_PIR_TWO),
		.wr_data_i (wdat & PIR_TWO_MSK), // see R20
		.set_i     ({periph_two_evt_i, 3'b000}), // see R19
		.flags_o   (pir_two)
	);

	// Pin-change summary flag is the OR of the pin flags and is read-only.
	logic pin_any;
	assign pin_any = |pin_flags[5:0];

	// Interrupt wake request, independent of the global enable.
	logic wake_req;
	logic periph_req;
	assign periph_req = irq_en_ff[PERIPH_EN_BIT] &&
		(|(pie_one_ff & pir_one) || |(pie_two_ff & pir_two & PIR_TWO_MSK)); // see R23
	assign wake_req = (irq_en_ff[TMR0_EN_BIT] && core_flags[2]) ||
		(irq_en_ff[EXT_EN_BIT] && core_flags[1]) ||
		(irq_en_ff[PIN_EN_BIT] && pin_any) || periph_req; // see R13

	// Watchdog mode: always, awake only, software enable, or off.
	always_comb begin
		case (wdt_mode_i)
			WDT_MODE_ON:     wdt_enabled = 1'b1;
			WDT_MODE_NSLEEP: wdt_enabled = !asleep;
			WDT_MODE_SW:     wdt_enabled = wdt_ctrl_ff[WDT_SW_EN_BIT];
			default:         wdt_enabled = 1'b0;
		endcase
	end
	assign wdt_timeout = wdt_enabled && slow_osc_tick_i && (wdt_cnt_ff == WDT_LAST);
	assign enter_sleep = (state_ff == ST_AWAKE) && sleep_instr_i && !wake_req; // see R01
	assign wake_evt    = (state_ff == ST_SLEEP) && (wake_req || wdt_timeout);
	assign ost_start   = wake_evt && crystal_mode_i;
	// Held clear on entry, on exit and for the whole start-up delay.
	assign wdt_clr = enter_sleep || wake_evt || (state_ff == ST_OST) || clear_wdt_i ||
		!wdt_enabled || reset_ff; // see R02, R15

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wdt_cnt_ff <= 24'h00_0000;
		end else if (wdt_clr) begin
			wdt_cnt_ff <= 24'h00_0000;
		end else if (slow_osc_tick_i) begin
			wdt_cnt_ff <= (wdt_cnt_ff == WDT_LAST) ? 24'h00_0000 : wdt_cnt_ff + 24'h00_0001;
		end
	end

	startup_timer #(
		.PERIODS(OST_LENGTH)
	) u_ost (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.start_i   (ost_start),
		.osc_tick_i(osc_tick_i),
		.done_o    (ost_done)
	);

	// Sequencer.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_AWAKE: begin
				if (enter_sleep) begin
					nxt_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				// An interrupt raised during entry is seen here on the first cycle.
				if (wake_evt) begin
					nxt_state = crystal_mode_i ? ST_OST : ST_RESUME; // see R17, R18
				end
			end
			ST_OST: begin
				if (ost_done) begin
					nxt_state = ST_RESUME;
				end
			end
			ST_RESUME: nxt_state = ST_AWAKE;
			default:   nxt_state = ST_AWAKE;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= ST_AWAKE;
		end else if (full_reset_req || reset_ff) begin
			state_ff <= ST_AWAKE; // see R10
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Reset output: pin, brown-out and power-on always; watchdog only while awake.
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reset_ff <= 1'b1;
		end else begin
			reset_ff <= full_reset_req || (wdt_timeout && !asleep); // see R09, R11
		end
	end

	// Core handshake pulses.
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prefetch_ff    <= 1'b0;
			nop_ff         <= 1'b0;
			resume_ff      <= 1'b0;
			vector_ff      <= 1'b0;
			gie_at_wake_ff <= 1'b0;
		end else begin
			prefetch_ff <= (state_ff == ST_AWAKE) && sleep_instr_i && !full_reset_req; // see R12
			nop_ff      <= (state_ff == ST_AWAKE) && sleep_instr_i && wake_req; // see R16
			resume_ff   <= (state_ff == ST_RESUME) && !full_reset_req; // see R11
			if (wake_evt) begin
				gie_at_wake_ff <= irq_en_ff[GLB_IRQ_EN_BIT] && wake_req;
			end
			// With the global enable set the core runs the prefetched word, then vectors.
			vector_ff <= (state_ff == ST_RESUME) && gie_at_wake_ff && !full_reset_req; // see R14
		end
	end

	// Software registers.
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_en_ff   <= 8'h00;
			pie_one_ff  <= 8'h00;
			pie_two_ff  <= 8'h00;
			wdt_ctrl_ff <= WDT_CTRL_RST;
			fall_en_ff  <= 8'h00;
			rise_en_ff  <= 8'h00;
		end else if (reset_ff) begin
			irq_en_ff   <= 8'h00;
			pie_one_ff  <= 8'h00;
			pie_two_ff  <= 8'h00;
			wdt_ctrl_ff <= WDT_CTRL_RST;
			fall_en_ff  <= 8'h00;
			rise_en_ff  <= 8'h00;
		end else if (wr_stb) begin
			case (paddr_i)
				OFS_IRQ_GLOBAL:  irq_en_ff   <= wdat & 8'hF8;
				OFS_PIE_ONE:     pie_one_ff  <= wdat;
				OFS_PIE_TWO:     pie_two_ff  <= wdat & PIR_TWO_MSK;
				OFS_WDT_CTRL:    wdt_ctrl_ff <= wdat & WDT_CTRL_MSK;
				OFS_PIN_FALL_EN: fall_en_ff  <= wdat & PIN_MSK;
				OFS_PIN_RISE_EN: rise_en_ff  <= wdat & PIN_MSK;
				default:         ;
			endcase
		end
	end

	// Status: hardware owns the two active-low flags, software the low three bits.
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			status_ff <= STATUS_RESET;
		end else if (full_reset_req) begin
			status_ff <= STATUS_RESET;
		end else begin
			if (wr_stb && paddr_i == OFS_STATUS) begin
				status_ff[2:0] <= wdat[2:0];
			end
			if (enter_sleep) begin
				status_ff[POWERDOWN_BIT] <= 1'b0; // see R03
				status_ff[TIMEOUT_BIT]   <= 1'b1; // see R03
			end else if (wdt_timeout) begin
				// A time-out marks the wake or the reset it caused.
				status_ff[TIMEOUT_BIT] <= 1'b0;
				if (!asleep) begin
					status_ff[POWERDOWN_BIT] <= 1'b1;
				end
			end else if (clear_wdt_i && !asleep) begin
				status_ff[POWERDOWN_BIT] <= 1'b1;
				status_ff[TIMEOUT_BIT]   <= 1'b1;
			end
		end
	end

	// Read mux.
	always_comb begin
		addr_hit = 1'b1;
		rdat     = 8'h00;
		case (paddr_i)
			OFS_IRQ_GLOBAL:  rdat = irq_en_ff | {5'b00000, core_flags[2:1], pin_any};
			OFS_PIE_ONE:     rdat = pie_one_ff;
			OFS_PIE_TWO:     rdat = pie_two_ff;
			OFS_PIR_ONE:     rdat = pir_one;
			OFS_PIR_TWO:     rdat = pir_two & PIR_TWO_MSK; // see R20
			OFS_STATUS:      rdat = status_ff & (STATUS_SW_MSK | 8'h18);
			OFS_WDT_CTRL:    rdat = wdt_ctrl_ff;
			OFS_PIN_FLAGS:   rdat = pin_flags & PIN_MSK;
			OFS_PIN_FALL_EN: rdat = fall_en_ff;
			OFS_PIN_RISE_EN: rdat = rise_en_ff;
			default:         addr_hit = 1'b0;
		endcase
	end

	// Read data is captured in the setup cycle so the access phase ends at once.
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_ff <= 32'h0000_0000;
		end else if (psel_i && !penable_i) begin
			prdata_ff <= (!pwrite_i && addr_hit) ? {24'h00_0000, rdat} : 32'h0000_0000;
		end
	end

	assign prdata_o  = prdata_ff;
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i && penable_i && !addr_hit;

	// Clock gating and keep-alive outputs.
	assign cpu_clk_en_o       = !asleep; // see R04
	assign slow_osc_en_o      = 1'b1; // see R05
	assign timer_osc_en_o     = 1'b1; // see R06
	assign converter_clk_en_o = 1'b1; // see R07
	assign cap_osc_en_o       = 1'b1; // see R07
	assign port_hold_o        = asleep; // see R08
	assign device_reset_o     = reset_ff; // see R10
	assign prefetch_o         = prefetch_ff;
	assign sleep_nop_o        = nop_ff;
	assign resume_o           = resume_ff;
	assign vector_o           = vector_ff;
	assign vector_addr_o      = IRQ_VECTOR;
	assign wdt_running_o      = wdt_enabled && !wdt_clr;
endmodule : sleep_wake_ctrl

// >>> design/sleep_wake_pkg.sv
// Constants, register map and state encoding of the sleep and wake controller.
// Notes on behaviour
// R01 - Power-down starts only when the core executes the power-down instruction.
// R02 - Entry clears the watchdog; it keeps counting if enabled during power-down.
// R03 - Entry clears the power-down flag and sets the time-out flag.
// R04 - The CPU clock is gated off while powered down.
// R05 - The slow internal oscillator keeps running during power-down.
// R06 - The secondary timer oscillator keeps running during power-down.
// R07 - Converter on dedicated clock and capacitive oscillator keep running.
// R08 - Port pins hold their drive state during power-down.
// R09 - Non-watchdog resets behave the same asleep as awake.
// R10 - External pin, brown-out and power-on resets wake with a full reset.
// R11 - Watchdog and interrupt wakes resume execution without reset.
// R12 - The next instruction is prefetched while the power-down instruction runs.
// R13 - Only individually enabled sources wake, regardless of the global enable.
// R14 - Global enable clear resumes in line; set runs prefetched then vectors to 0004h.
// R15 - The watchdog is cleared on every exit from power-down.
// R16 - A pending enabled interrupt makes the instruction a no-op, flags untouched.
// R17 - An interrupt during entry completes entry then wakes at once.
// R18 - Crystal modes wait 1024 oscillator periods before resuming; others do not.
// R19 - Second flag register holds five pending flags in bits 7 to 3, reset 0.
// R20 - Bits 2 to 0 of the second flag register read as zero.
// R21 - Software places a no-op after the power-down instruction when needed.
// R22 - Flags set on their event regardless of individual or global enables.
// R23 - Wake request is OR of flag AND enable; peripherals also need their enable.
package sleep_wake_pkg;
	// Register byte offsets on the APB bus.
	localparam logic [7:0] OFS_IRQ_GLOBAL   = 8'h00;
	localparam logic [7:0] OFS_PIE_ONE      = 8'h04;
	localparam logic [7:0] OFS_PIE_TWO      = 8'h08;
	localparam logic [7:0] OFS_PIR_ONE      = 8'h0C;
	localparam logic [7:0] OFS_PIR_TWO      = 8'h10;
	localparam logic [7:0] OFS_STATUS       = 8'h14;
	localparam logic [7:0] OFS_WDT_CTRL     = 8'h18;
	localparam logic [7:0] OFS_PIN_FLAGS    = 8'h1C;
	localparam logic [7:0] OFS_PIN_FALL_EN  = 8'h20;
	localparam logic [7:0] OFS_PIN_RISE_EN  = 8'h24;
	// Global interrupt control fields.
	localparam int GLB_IRQ_EN_BIT   = 7;
	localparam int PERIPH_EN_BIT    = 6;
	localparam int TMR0_EN_BIT      = 5;
	localparam int EXT_EN_BIT       = 4;
	localparam int PIN_EN_BIT       = 3;
	localparam int TMR0_FLAG_BIT    = 2;
	localparam int EXT_FLAG_BIT     = 1;
	localparam int PIN_FLAG_BIT     = 0;
	// Status fields; both flags are active low.
	localparam int TIMEOUT_BIT      = 4;
	localparam int POWERDOWN_BIT    = 3;
	localparam logic [7:0] STATUS_RESET  = 8'h18;
	localparam logic [7:0] STATUS_SW_MSK = 8'h07;
	// Second flag and enable registers: bits 7..3 used.
	localparam logic [7:0] PIR_TWO_MSK   = 8'hF8;
	localparam logic [7:0] PIR_TWO_RESET = 8'h00;
	localparam logic [7:0] PIN_MSK       = 8'h3F;
	localparam logic [7:0] WDT_CTRL_MSK  = 8'h3F;
	localparam logic [7:0] WDT_CTRL_RST  = 8'h16;
	localparam int WDT_SW_EN_BIT    = 0;
	// Watchdog configuration modes.
	localparam logic [1:0] WDT_MODE_OFF    = 2'h0;
	localparam logic [1:0] WDT_MODE_SW     = 2'h1;
	localparam logic [1:0] WDT_MODE_NSLEEP = 2'h2;
	localparam logic [1:0] WDT_MODE_ON     = 2'h3;
	// Oscillator start-up delay in oscillator periods.
	localparam int OST_PERIODS      = 1024;
	localparam logic [15:0] IRQ_VECTOR = 16'h0004;
	typedef enum logic [2:0] {
		ST_AWAKE  = 3'b000,
		ST_SLEEP  = 3'b001,
		ST_OST    = 3'b010,
		ST_RESUME = 3'b011
	} pwr_state_t;
endpackage : sleep_wake_pkg

// >>> design/startup_timer.sv
// Counts oscillator periods after a wake from a crystal mode.
`timescale 1ns/10ps
module startup_timer
	import sleep_wake_pkg::*;
#(
	parameter int PERIODS = OST_PERIODS
) (
	// Clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	// Control
	input  wire logic start_i,
	input  wire logic osc_tick_i,
	output logic      done_o
);
	initial begin
		if (PERIODS < 1 || PERIODS > 65535) $error("startup_timer PERIODS out of range");
	end
	localparam logic [15:0] LAST = 16'(PERIODS - 1);
	logic [15:0] cnt_ff;
	logic        run_ff;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff <= 16'h0000;
			run_ff <= 1'b0;
		end else if (start_i) begin
			cnt_ff <= 16'h0000;
			run_ff <= 1'b1;
		end else if (run_ff && osc_tick_i) begin
			cnt_ff <= cnt_ff + 16'h0001;
			if (cnt_ff == LAST) begin
				run_ff <= 1'b0;
			end
		end
	end
	assign done_o = run_ff && osc_tick_i && (cnt_ff == LAST); // see R18
endmodule : startup_timer

// >>> design/sticky_flags.sv
// Bank of hardware-set, software-written pending flags.
`timescale 1ns/10ps
module sticky_flags
	import sleep_wake_pkg::*;
#(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         sys_clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         sync_clr_i,
	// Software write and hardware set
	input  wire logic         wr_en_i,
	input  wire logic [W-1:0] wr_data_i,
	input  wire logic [W-1:0] set_i,
	output logic      [W-1:0] flags_o
);
	initial begin
		if (W < 1) $error("sticky_flags needs W >= 1");
	end
	logic [W-1:0] flags_ff;
	// A set in the cycle of a software clear wins, so no event is lost.
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags_ff <= '0;
		end else if (sync_clr_i) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= (wr_en_i ? wr_data_i : flags_ff) | set_i; // see R22
		end
	end
	assign flags_o = flags_ff;
endmodule : sticky_flags

// >>> testbench/core_model.sv
// Stand-in for the processor core and its running oscillator.
`timescale 1ns/10ps
module core_model (
	// Clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	// Requests and answers
	input  wire logic req_i,
	input  wire logic resume_i,
	input  wire logic nop_i,
	output logic      sleep_instr_o,
	output logic      osc_tick_o,
	output logic      asleep_o
);
	// A no-op follows power-down, so nothing is issued until resume or the no-op answer.
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) sleep_instr_o <= 1'b0;
		else sleep_instr_o <= req_i && !asleep_o;
	end
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) asleep_o <= 1'b0;
		else if (resume_i || nop_i) asleep_o <= 1'b0;
		else if (sleep_instr_o) asleep_o <= 1'b1;
	end
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) osc_tick_o <= 1'b0;
		else osc_tick_o <= !osc_tick_o;
	end
endmodule : core_model

// >>> testbench/sleep_wake_checker.sv
// Port-level assertions for the sleep and wake controller.
`timescale 1ns/10ps
module sleep_wake_checker
	import sleep_wake_pkg::*;
(
	// Clock and reset
	input wire logic        sys_clk_i,
	input wire logic        rst_n_i,
	// Core side
	input wire logic        sleep_instr_i,
	input wire logic        cpu_clk_en_o,
	input wire logic        prefetch_o,
	input wire logic        sleep_nop_o,
	input wire logic        resume_o,
	input wire logic        vector_o,
	input wire logic [15:0] vector_addr_o,
	// Resets
	input wire logic        external_reset_pin_i,
	input wire logic        brownout_reset_i,
	input wire logic        por_reset_i,
	input wire logic        device_reset_o,
	// Clocks kept alive and pins
	input wire logic        slow_osc_en_o,
	input wire logic        timer_osc_en_o,
	input wire logic        converter_clk_en_o,
	input wire logic        cap_osc_en_o,
	input wire logic        port_hold_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// A reset request in the same cycle outranks the instruction.
	sequence s_enter;
		cpu_clk_en_o && sleep_instr_i && !por_reset_i && !brownout_reset_i && !external_reset_pin_i;
	endsequence
	sequence s_slept;
		s_enter ##1 !sleep_nop_o;
	endsequence
	entry_by_instr_a: assert property ($fell(cpu_clk_en_o) |-> $past(sleep_instr_i))
		else $error("Clock stopped without the instruction");
	prefetch_next_a: assert property (s_enter |=> prefetch_o)
		else $error("No prefetch after the instruction");
	clk_gated_a: assert property (s_slept |-> !cpu_clk_en_o)
		else $error("CPU clock running after entry");
	pins_held_a: assert property (s_slept |-> port_hold_o)
		else $error("Port hold not raised after entry");
	nop_stays_awake_a: assert property (sleep_nop_o |-> $past(sleep_instr_i) && cpu_clk_en_o)
		else $error("No-op entry stopped the CPU clock");
	osc_alive_a: assert property (slow_osc_en_o && timer_osc_en_o)
		else $error("Slow or timer oscillator stopped");
	conv_alive_a: assert property (converter_clk_en_o && cap_osc_en_o)
		else $error("Converter or capacitive clock stopped");
	vector_pair_a: assert property (vector_o |-> resume_o && vector_addr_o == IRQ_VECTOR)
		else $error("Vector without resume or bad address");
	resume_awake_a: assert property (resume_o |-> cpu_clk_en_o)
		else $error("Resume while the CPU clock is stopped");
	full_reset_a: assert property ((por_reset_i || brownout_reset_i || external_reset_pin_i)
		|-> ##[1:2] device_reset_o)
		else $error("Reset request not passed on");
endmodule : sleep_wake_checker

bind sleep_wake_ctrl sleep_wake_checker u_chk (
	.sys_clk_i, .rst_n_i, .sleep_instr_i, .cpu_clk_en_o, .prefetch_o, .sleep_nop_o, .resume_o,
	.vector_o, .vector_addr_o, .external_reset_pin_i, .brownout_reset_i, .por_reset_i,
	.device_reset_o, .slow_osc_en_o, .timer_osc_en_o, .converter_clk_en_o, .cap_osc_en_o,
	.port_hold_o
);

// >>> testbench/tb_top.sv
// Self-checking bench of the sleep and wake controller.
`timescale 1ns/10ps
module tb_top;
	import sleep_wake_pkg::*;
	localparam int OST_LEN = 4;
	logic        sys_clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic        sleep_instr_i, req, asleep, cpu_clk_en_o, prefetch_o, sleep_nop_o;
	logic        resume_o, vector_o, por_reset_i, device_reset_o, crystal_mode_i;
	logic        external_reset_pin_i, wdt_running_o;
	logic        slow_osc_tick_i, osc_tick_i, ext_int_evt_i, err_seen, v, slow_on, port_hold_o;
	logic [1:0]  wdt_mode_i;
	logic [5:0]  pin_rise_i;
	logic [7:0]  periph_one_evt_i;
	logic [4:0]  periph_two_evt_i;
	int          error_cnt, cmp_count, n;

	sleep_wake_ctrl #(.WDT_TICKS(4), .OST_LENGTH(OST_LEN)) DUT (
		.sys_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
		.pready_o, .pslverr_o, .sleep_instr_i, .clear_wdt_i(1'b0), .cpu_clk_en_o, .prefetch_o,
		.sleep_nop_o, .resume_o, .vector_o, .vector_addr_o(), .external_reset_pin_i,
		.brownout_reset_i(1'b0), .por_reset_i, .device_reset_o, .wdt_mode_i, .crystal_mode_i,
		.slow_osc_tick_i, .osc_tick_i, .slow_osc_en_o(), .timer_osc_en_o(),
		.converter_clk_en_o(), .cap_osc_en_o(), .port_hold_o, .tmr0_evt_i(1'b0),
		.ext_int_evt_i, .pin_rise_i, .pin_fall_i(6'h0), .periph_one_evt_i, .periph_two_evt_i,
		.wdt_running_o
	);
	core_model u_core (.sys_clk_i, .rst_n_i, .req_i(req),
		.resume_i(resume_o), .nop_i(sleep_nop_o), .sleep_instr_o(sleep_instr_i),
		.osc_tick_o(osc_tick_i), .asleep_o(asleep));

	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) slow_osc_tick_i <= slow_on && !slow_osc_tick_i;

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		do @(posedge sys_clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		err_seen = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic reg_is(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, e);
	endtask : reg_is
	task automatic enter(input logic nop);
		@(posedge sys_clk_i);
		req <= 1'b1;
		@(posedge sys_clk_i);
		req <= 1'b0;
		repeat (8) begin
			@(negedge sys_clk_i);
			if (prefetch_o === 1'b1 || sleep_nop_o === 1'b1) break;
		end
		chk("nop", sleep_nop_o, nop);
		chk("clk_en", cpu_clk_en_o, nop);
		chk("hold", port_hold_o, !nop);
	endtask : enter
	task automatic wait_res(output logic vec);
		vec = 1'bx;
		n = 0;
		repeat (400) begin
			@(negedge sys_clk_i);
			if (osc_tick_i === 1'b1) n++;
			if (resume_o === 1'b1) begin
				vec = vector_o;
				break;
			end
		end
		chk("resume", resume_o, 1'b1);
		chk("clk back", cpu_clk_en_o, 1'b1);
	endtask : wait_res

	task automatic s_regs;
		reg_is(OFS_PIR_TWO, 32'h0, "periph_irq_flags_two reset");
		reg_is(OFS_STATUS, 32'(STATUS_RESET), "status reset");
		reg_is(8'h3C, 32'h0, "unmapped");
		chk("slverr", err_seen, 1'b1);
	endtask : s_regs
	task automatic s_flags;
		@(posedge sys_clk_i);
		periph_two_evt_i <= 5'h1F;
		@(posedge sys_clk_i);
		periph_two_evt_i <= 5'h00;
		reg_is(OFS_PIR_TWO, 32'(PIR_TWO_MSK), "periph_irq_flags_two set");
		apb(1'b1, OFS_PIR_TWO, 32'h7);
		reg_is(OFS_PIR_TWO, 32'h0, "periph_irq_flags_two clr");
	endtask : s_flags
	task automatic s_pending;
		apb(1'b1, OFS_IRQ_GLOBAL, 32'(1) << EXT_EN_BIT);
		@(posedge sys_clk_i);
		ext_int_evt_i <= 1'b1;
		@(posedge sys_clk_i);
		ext_int_evt_i <= 1'b0;
		enter(1'b1);
		reg_is(OFS_STATUS, 32'(STATUS_RESET), "status kept");
		apb(1'b1, OFS_IRQ_GLOBAL, 32'(1) << EXT_EN_BIT);
	endtask : s_pending
	task automatic s_inline;
		enter(1'b0);
		reg_is(OFS_STATUS, 32'h0000_0010, "status asleep");
		@(posedge sys_clk_i);
		ext_int_evt_i <= 1'b1;
		@(posedge sys_clk_i);
		ext_int_evt_i <= 1'b0;
		wait_res(v);
		chk("no vector", v, 1'b0);
		apb(1'b1, OFS_IRQ_GLOBAL, 32'(1) << EXT_EN_BIT);
	endtask : s_inline
	task automatic s_vector;
		apb(1'b1, OFS_IRQ_GLOBAL, (32'(1) << GLB_IRQ_EN_BIT) | (32'(1) << PERIPH_EN_BIT));
		apb(1'b1, OFS_PIE_ONE, 32'h1);
		enter(1'b0);
		@(posedge sys_clk_i);
		periph_two_evt_i <= 5'h01;
		@(posedge sys_clk_i);
		periph_two_evt_i <= 5'h00;
		repeat (20) @(negedge sys_clk_i);
		chk("masked", cpu_clk_en_o, 1'b0);
		@(posedge sys_clk_i);
		periph_one_evt_i <= 8'h01;
		@(posedge sys_clk_i);
		periph_one_evt_i <= 8'h00;
		wait_res(v);
		chk("vector", v, 1'b1);
		apb(1'b1, OFS_PIR_ONE, 32'h0);
		apb(1'b1, OFS_PIR_TWO, 32'h0);
		apb(1'b1, OFS_IRQ_GLOBAL, 32'h0);
	endtask : s_vector
	task automatic s_xtal;
		crystal_mode_i <= 1'b1;
		apb(1'b1, OFS_PIN_RISE_EN, 32'h1);
		apb(1'b1, OFS_IRQ_GLOBAL, 32'(1) << PIN_EN_BIT);
		enter(1'b0);
		@(posedge sys_clk_i);
		pin_rise_i <= 6'h01;
		@(posedge sys_clk_i);
		pin_rise_i <= 6'h00;
		wait_res(v);
		chk("ost", 32'(n >= OST_LEN), 32'h1);
		apb(1'b1, OFS_PIN_FLAGS, 32'h0);
		apb(1'b1, OFS_IRQ_GLOBAL, 32'h0);
		crystal_mode_i <= 1'b0;
	endtask : s_xtal
	task automatic s_wdt;
		wdt_mode_i <= WDT_MODE_ON;
		enter(1'b0);
		chk("wdt run", wdt_running_o, 1'b1);
		slow_on <= 1'b1;
		wait_res(v);
		slow_on <= 1'b0;
		chk("wdt wake", v, 1'b0);
		reg_is(OFS_STATUS, 32'h0, "status wdt");
		slow_on <= 1'b1;
		repeat (2) @(negedge sys_clk_i);
		slow_on <= 1'b0;
		repeat (4) @(negedge sys_clk_i);
		chk("wdt cleared", device_reset_o, 1'b0);
		@(posedge sys_clk_i);
		wdt_mode_i <= WDT_MODE_OFF;
	endtask : s_wdt
	task automatic s_por;
		enter(1'b0);
		@(posedge sys_clk_i);
		por_reset_i <= 1'b1;
		@(posedge sys_clk_i);
		por_reset_i <= 1'b0;
		v = 1'b0;
		repeat (4) begin
			@(negedge sys_clk_i);
			if (device_reset_o === 1'b1) v = 1'b1;
		end
		chk("full reset", v, 1'b1);
		chk("awake", cpu_clk_en_o, 1'b1);
		reg_is(OFS_STATUS, 32'(STATUS_RESET), "status por");
		external_reset_pin_i <= 1'b1;
		@(posedge sys_clk_i);
		external_reset_pin_i <= 1'b0;
		@(negedge sys_clk_i);
		chk("pin reset", device_reset_o, 1'b1);
	endtask : s_por

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up

	// The tests take a few hundred cycles; this 10000-cycle limit leaves margin.
	initial begin
		#40us;
		error_cnt++;
		wrap_up();
	end
	initial begin
		{rst_n_i, psel_i, penable_i, pwrite_i, req, por_reset_i, crystal_mode_i} = 7'h0;
		{ext_int_evt_i, slow_on, external_reset_pin_i} = 3'h0;
		paddr_i = 8'h0;
		pwdata_i = 32'h0;
		wdt_mode_i = WDT_MODE_OFF;
		pin_rise_i = 6'h0;
		periph_one_evt_i = 8'h0;
		periph_two_evt_i = 5'h0;
		repeat (10) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		s_regs();
		s_flags();
		s_pending();
		s_inline();
		s_vector();
		s_xtal();
		s_wdt();
		s_por();
		wrap_up();
	end
endmodule : tb_top
